/* core/atcc_channel.sv */
// One capture/compare channel: source mux, edge detect, value and output
`timescale 1ns/1ps
`default_nettype none
module atcc_channel
	import atcc_pkg::*;
(
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire logic [7:0]             control,
	input  wire logic [atcc_pkg::SEL_W-1:0] src_sel,
	input  wire logic [7:0]             sources,
	input  wire logic [atcc_pkg::VAL_W-1:0] phase_counter,
	input  wire logic                   wr_high,
	input  wire logic                   wr_low,
	input  wire logic [7:0]             wdata,
	output logic [atcc_pkg::VAL_W-1:0]  channel_value,
	output logic                        event_pulse,
	output logic                        channel_output
);
	logic [1:0]            high_hold_reg;
	logic                  src_prev_reg;
	logic                  src_now;
	logic                  enable, capture_mode, edge_fall, out_pol;
	logic                  capture_hit, compare_hit;
	logic                  match_prev_reg;
	logic                  active_reg;

	assign enable       = control[CTL_EN_BIT];
	assign capture_mode = control[CTL_MODE_BIT];
	assign edge_fall    = control[CTL_CAPP_BIT];
	assign out_pol      = control[CTL_POL_BIT];

	assign src_now = sources[src_sel];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_prev_reg <= 1'b0;
		end else begin
			src_prev_reg <= src_now;
		end
	end

	assign capture_hit = enable && capture_mode &&
		(edge_fall ? (src_prev_reg && !src_now) : (!src_prev_reg && src_now));

	// match only on arrival, so a parked phase raises one event
	assign compare_hit = enable && !capture_mode &&
		(phase_counter == channel_value) && !match_prev_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			match_prev_reg <= 1'b0;
		end else begin
			match_prev_reg <= enable && !capture_mode &&
				(phase_counter == channel_value);
		end
	end

	// high byte held until low write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			high_hold_reg <= VAL_RESET[VAL_W-1:8];
		end else if (wr_high) begin
			high_hold_reg <= wdata[1:0];
		end
	end

	// capture load, software writes only in compare mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			channel_value <= VAL_RESET;
		end else if (capture_hit) begin
			channel_value <= phase_counter;
		end else if (wr_low && !capture_mode) begin
			channel_value <= {high_hold_reg, wdata};
		end
	end

	assign event_pulse = capture_hit || compare_hit;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			active_reg <= 1'b0;
		end else begin
			active_reg <= event_pulse;
		end
	end

	assign channel_output = active_reg ^ out_pol;
endmodule : atcc_channel
`default_nettype wire

/* core/atcc_pkg.sv */
// Package: register map, field layout and encodings for the capture/compare
package atcc_pkg;
	localparam int NCH     = 3;
	localparam int VAL_W   = 10;
	localparam int DATA_W  = 32;
	localparam int ADDR_W  = 12;
	localparam int SEL_W   = 3;

	// Register byte offsets, channel registers step by CH_STRIDE
	localparam logic [ADDR_W-1:0] OFF_VAL_HIGH  = 12'h000;
	localparam logic [ADDR_W-1:0] OFF_VAL_LOW   = 12'h004;
	localparam logic [ADDR_W-1:0] OFF_CONTROL   = 12'h008;
	localparam logic [ADDR_W-1:0] OFF_SRC_SEL   = 12'h00C;
	localparam logic [ADDR_W-1:0] CH_STRIDE     = 12'h010;
	localparam logic [ADDR_W-1:0] OFF_INT_EN    = 12'h040;
	localparam logic [ADDR_W-1:0] OFF_INT_FLAGS = 12'h044;

	// Control register bit positions
	localparam int CTL_MODE_BIT = 0;
	localparam int CTL_CAPP_BIT = 3;
	localparam int CTL_POL_BIT  = 4;
	localparam int CTL_EN_BIT   = 7;
	localparam logic [7:0] CTL_MASK = 8'h99;

	localparam logic [7:0] CTL_RESET = 8'h00;
	localparam logic [SEL_W-1:0] SEL_RESET = 3'h0;
	localparam logic [VAL_W-1:0] VAL_RESET = 10'h000;
	localparam logic [NCH-1:0] FLAG_RESET = 3'h0;

	// Capture source codes
	localparam logic [SEL_W-1:0] SRC_PIN  = 3'h0;
	localparam logic [SEL_W-1:0] SRC_CMP1 = 3'h1;
	localparam logic [SEL_W-1:0] SRC_CMP2 = 3'h2;
	localparam logic [SEL_W-1:0] SRC_LC1  = 3'h3;
	localparam logic [SEL_W-1:0] SRC_LC2  = 3'h4;
	localparam logic [SEL_W-1:0] SRC_LC3  = 3'h5;
	localparam logic [SEL_W-1:0] SRC_LC4  = 3'h6;
	localparam logic [SEL_W-1:0] SRC_WG   = 3'h7;
endpackage : atcc_pkg

/* core/atcc_top.sv */
// Angular timer capture/compare block with APB register slave
//
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module atcc_top
	import atcc_pkg::*;
(
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [atcc_pkg::ADDR_W-1:0] paddr,
	input  wire logic [atcc_pkg::DATA_W-1:0] pwdata,
	output logic      [atcc_pkg::DATA_W-1:0] prdata,
	output logic                             pready,
	output logic                             pslverr,
	input  wire logic [atcc_pkg::VAL_W-1:0]  phase_counter,
	input  wire logic [atcc_pkg::NCH-1:0]    channel_capture_pin,
	input  wire logic                        comparator_one_synced,
	input  wire logic                        comparator_two_synced,
	input  wire logic                        logic_cell_one_output,
	input  wire logic                        logic_cell_two_output,
	input  wire logic                        logic_cell_three_output,
	input  wire logic                        logic_cell_four_output,
	input  wire logic                        waveform_generator_event,
	output logic      [atcc_pkg::NCH-1:0]    channel_output,
	output logic                             irq
);
	import atcc_pkg::*;

	typedef enum logic [2:0] {
		ATCC_HIGH, ATCC_LOW, ATCC_CTL, ATCC_SEL, ATCC_NONE
	} atcc_field_t;

	logic [7:0]       control_reg [NCH];
	logic [SEL_W-1:0] src_sel_reg [NCH];
	logic [NCH-1:0]   flag_reg;
	logic [NCH-1:0]   flag_enable_reg;
	logic [VAL_W-1:0] value [NCH];
	logic [NCH-1:0]   event_pulse;
	logic [NCH-1:0]   wr_high, wr_low;
	logic             wr_en, rd_ok;
	logic [DATA_W-1:0] rdata_next;

	// Returns the field of a channel-window address
	function automatic atcc_field_t field_of(input logic [ADDR_W-1:0] a,
		input int ch);
		logic [ADDR_W-1:0] base;
		base = CH_STRIDE * ADDR_W'(ch);
		if (a == base + OFF_VAL_HIGH) field_of = ATCC_HIGH;
		else if (a == base + OFF_VAL_LOW) field_of = ATCC_LOW;
		else if (a == base + OFF_CONTROL) field_of = ATCC_CTL;
		else if (a == base + OFF_SRC_SEL) field_of = ATCC_SEL;
		else field_of = ATCC_NONE;
	endfunction : field_of

	// Zero-wait slave; writes commit on the access cycle
	assign pready = 1'b1;
	assign wr_en  = psel && penable && pwrite;

	always_comb begin
		rd_ok = (paddr == OFF_INT_EN) || (paddr == OFF_INT_FLAGS);
		for (int c = 0; c < NCH; c++) begin
			if (field_of(paddr, c) != ATCC_NONE) rd_ok = 1'b1;
		end
	end
	assign pslverr = psel && penable && !rd_ok;

	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_ch
			logic [7:0] srcs;
			assign srcs = {waveform_generator_event, logic_cell_four_output,
				logic_cell_three_output, logic_cell_two_output,
				logic_cell_one_output, comparator_two_synced,
				comparator_one_synced, channel_capture_pin[g]};
			assign wr_high[g] = wr_en && field_of(paddr, g) == ATCC_HIGH;
			assign wr_low[g]  = wr_en && field_of(paddr, g) == ATCC_LOW;

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					control_reg[g] <= CTL_RESET;
				end else if (wr_en && field_of(paddr, g) == ATCC_CTL) begin
					control_reg[g] <= pwdata[7:0] & CTL_MASK;
				end
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					src_sel_reg[g] <= SEL_RESET;
				end else if (wr_en && field_of(paddr, g) == ATCC_SEL) begin
					src_sel_reg[g] <= pwdata[SEL_W-1:0];
				end
			end

			atcc_channel u_ch (
				.pclk           (pclk),
				.presetn        (presetn),
				.control        (control_reg[g]),
				.src_sel        (src_sel_reg[g]),
				.sources        (srcs),
				.phase_counter  (phase_counter),
				.wr_high        (wr_high[g]),
				.wr_low         (wr_low[g]),
				.wdata          (pwdata[7:0]),
				.channel_value  (value[g]),
				.event_pulse    (event_pulse[g]),
				.channel_output (channel_output[g])
			);
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_enable_reg <= FLAG_RESET;
		end else if (wr_en && paddr == OFF_INT_EN) begin
			flag_enable_reg <= pwdata[NCH-1:0];
		end
	end

	// sticky flags, write one clears, set wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_reg <= FLAG_RESET;
		end else if (wr_en && paddr == OFF_INT_FLAGS) begin
			flag_reg <= (flag_reg & ~pwdata[NCH-1:0]) | event_pulse;
		end else begin
			flag_reg <= flag_reg | event_pulse;
		end
	end

	assign irq = |(flag_reg & flag_enable_reg);

	// Read mux, unused bits zero
	always_comb begin
		rdata_next = '0;
		if (paddr == OFF_INT_EN) begin
			rdata_next[NCH-1:0] = flag_enable_reg;
		end else if (paddr == OFF_INT_FLAGS) begin
			rdata_next[NCH-1:0] = flag_reg;
		end
		for (int c = 0; c < NCH; c++) begin
			case (field_of(paddr, c))
				ATCC_HIGH: rdata_next[1:0] = value[c][VAL_W-1:8];
				ATCC_LOW:  rdata_next[7:0] = value[c][7:0];
				ATCC_CTL:  rdata_next[7:0] = control_reg[c];
				ATCC_SEL:  rdata_next[SEL_W-1:0] = src_sel_reg[c];
				default: ;
			endcase
		end
	end

	// Read data registered in setup phase, stable through access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (psel && !penable && !pwrite) begin
			prdata <= rdata_next;
		end
	end
endmodule : atcc_top
`default_nettype wire

/* sim/atcc_far_model.sv */
// Far-side model: phase counter and synchronous capture sources
`timescale 1ns/1ps
`default_nettype none
module atcc_far_model (
	input  wire logic       pclk,
	input  wire logic       run,
	input  wire logic       load,
	input  wire logic [9:0] ld_val,
	input  wire logic [7:0] src,
	output logic      [9:0] phase_counter,
	output logic      [7:0] src_q
);
	// Sources leave a flop, as the real ones are synchronous
	always_ff @(posedge pclk) begin
		phase_counter <= load ? ld_val : phase_counter + {9'h000, run};
		src_q <= src;
	end
endmodule : atcc_far_model
`default_nettype wire

/* sim/atcc_top_asserts.sv */
// Port-level assertions for the capture/compare block
`timescale 1ns/1ps
`default_nettype none
module atcc_top_asserts
	import atcc_pkg::*;
(
	input wire logic                        pclk,
	input wire logic                        presetn,
	input wire logic                        psel,
	input wire logic                        penable,
	input wire logic                        pwrite,
	input wire logic [atcc_pkg::ADDR_W-1:0] paddr,
	input wire logic [atcc_pkg::DATA_W-1:0] prdata,
	input wire logic                        pslverr,
	input wire logic [atcc_pkg::NCH-1:0]    channel_output,
	input wire logic                        irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic acc, rd, chn, map;
	assign acc = psel && penable;
	assign rd = acc && !pwrite;
	assign chn = paddr < 12'h030;
	assign map = paddr[1:0] == 2'h0
		&& (chn || paddr == OFF_INT_EN || paddr == OFF_INT_FLAGS);
	a_map_error: assert property (acc && !map |-> pslverr)
		else $error("no error on unmapped access");
	a_sel_zero: assert property (rd && chn && paddr[3:0] == 4'hC
		|-> prdata[31:3] == 29'h0) else $error("select upper bits set");
	a_high_zero: assert property (rd && chn && paddr[3:0] == 4'h0
		|-> prdata[31:2] == 30'h0) else $error("value high upper bits set");
	a_low_zero: assert property (rd && chn && paddr[3:0] == 4'h4
		|-> prdata[31:8] == 24'h0) else $error("value low upper bits set");
	a_ctl_bits: assert property (rd && chn && paddr[3:0] == 4'h8
		|-> (prdata & ~{24'h0, CTL_MASK}) == 32'h0)
		else $error("control unused bits set");
	a_flag_zero: assert property (rd && paddr == OFF_INT_FLAGS
		|-> prdata[31:3] == 29'h0) else $error("flag upper bits set");
	a_irq_sticky: assert property ($fell(irq) |-> $past(acc && pwrite))
		else $error("interrupt fell without a write");
	a_irq_cause: assert property ($rose(irq) && !$past(acc && pwrite)
		|=> channel_output != $past(channel_output))
		else $error("event without output pulse");
	cover property (rd && paddr == OFF_INT_FLAGS && prdata[2:0] != 3'h0);
	cover property ($rose(irq));
	cover property (acc && !map);
endmodule : atcc_top_asserts
bind atcc_top atcc_top_asserts u_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.prdata(prdata), .pslverr(pslverr), .channel_output(channel_output),
	.irq(irq));
`default_nettype wire

/* sim/tb_top.sv */
// Self-checking bench for the capture/compare block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import atcc_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        irq, run, load;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [31:0] q[$];
	logic [9:0]  ld_val, phase;
	logic [7:0]  src, src_q;
	logic [2:0]  cout;
	int          fail_count, cmp_count, seed, k, n0, n2;

	atcc_far_model u_far (.pclk(pclk), .run(run), .load(load),
		.ld_val(ld_val), .src(src), .phase_counter(phase), .src_q(src_q));
	atcc_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .phase_counter(phase),
		.channel_capture_pin({3{src_q[0]}}),
		.comparator_one_synced(src_q[1]), .comparator_two_synced(src_q[2]),
		.logic_cell_one_output(src_q[3]), .logic_cell_two_output(src_q[4]),
		.logic_cell_three_output(src_q[5]),
		.logic_cell_four_output(src_q[6]),
		.waveform_generator_event(src_q[7]), .channel_output(cout),
		.irq(irq));

	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	task test_done;
		$display("mismatches %0d comparisons %0d", fail_count, cmp_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : test_done

	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: %h not %h", $time, got, exp);
		end
	endtask : chk

	task stall;
		fail_count++;
		test_done();
	endtask : stall

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		for (n = 0; pready !== 1'b1; n++) begin
			if (n == 20)
				stall();
			@(posedge pclk);
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task rd(input logic [11:0] a, input logic [31:0] e);
		q.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask : rd

	task wait_irq;
		int n;
		for (n = 0; irq !== 1'b1; n++) begin
			if (n == 30)
				stall();
			@(posedge pclk);
		end
	endtask : wait_irq

	// Reads are noted when issued and judged when the access completes
	// Pulse cycles counted on the active-high channels
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite && q.size() > 0)
			chk(prdata, q.pop_front());
		if (cout[0] === 1'b1)
			n0++;
		if (cout[2] === 1'b1)
			n2++;
	end

	initial begin
		{psel, penable, pwrite, run, load, presetn} = 6'h00;
		{paddr, pwdata, src, ld_val} = '0;
		{fail_count, cmp_count, seed} = {32'h0, 32'h0, 32'h7E8E};
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (k = 0; k < 18; k++)
			rd(12'(k * 4), 32'h0);
		wr(12'h030, 32'hFF);
		rd(12'h030, 32'h0);
		wr(OFF_INT_EN, 32'h7);
		load <= 1'b1;
		for (k = 0; k < 8; k++) begin
			wr(OFF_SRC_SEL, 32'hF8 | 32'(k));
			rd(OFF_SRC_SEL, 32'(k));
			wr(OFF_CONTROL, 32'h81);
			src <= 8'h00;
			ld_val <= 10'($random(seed));
			repeat (3) @(posedge pclk);
			src <= ~(8'h01 << k);
			repeat (4) @(posedge pclk);
			rd(OFF_INT_FLAGS, 32'h0);
			src <= 8'hFF;
			wait_irq();
			wr(OFF_VAL_LOW, 32'h5A);
			rd(OFF_VAL_LOW, {24'h0, ld_val[7:0]});
			rd(OFF_VAL_HIGH, {30'h0, ld_val[9:8]});
			rd(OFF_INT_FLAGS, 32'h1);
			wr(OFF_INT_FLAGS, 32'h1);
		end
		chk(32'(n0), 32'h8);
		wr(CH_STRIDE + OFF_SRC_SEL, 32'h0);
		wr(CH_STRIDE + OFF_CONTROL, 32'h99);
		#1 chk({31'h0, cout[1]}, 32'h1);
		@(posedge pclk);
		ld_val <= 10'($random(seed));
		src <= 8'h00;
		wait_irq();
		rd(CH_STRIDE + OFF_VAL_LOW, {24'h0, ld_val[7:0]});
		wr(OFF_INT_EN, 32'h5);
		#1 chk({31'h0, irq}, 32'h0);
		@(posedge pclk);
		rd(OFF_INT_FLAGS, 32'h2);
		wr(OFF_INT_FLAGS, 32'h2);
		wr(OFF_INT_EN, 32'h7);
		ld_val <= 10'h230;
		wr(12'h020 + OFF_CONTROL, 32'h80);
		wr(12'h020 + OFF_VAL_HIGH, 32'h2);
		rd(12'h020 + OFF_VAL_HIGH, 32'h0);
		wr(12'h020 + OFF_VAL_LOW, 32'h34);
		rd(12'h020 + OFF_VAL_HIGH, 32'h2);
		load <= 1'b0;
		run <= 1'b1;
		wait_irq();
		rd(OFF_INT_FLAGS, 32'h4);
		chk(32'(n2), 32'h1);
		run <= 1'b0;
		wr(OFF_INT_FLAGS, 32'h7);
		wr(OFF_CONTROL, 32'h01);
		src <= 8'h80;
		repeat (4) @(posedge pclk);
		rd(OFF_INT_FLAGS, 32'h0);
		chk(32'(n0), 32'h8);
		test_done();
	end
endmodule : tb_top
`default_nettype wire
